// file: rtl/ppi_packet_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - packet size is taken from the upper half of the size register and used
// - lower half reports smallest size giving the top frame rate
// - recommended size is recomputed on any setting change
// - packets per frame is a full quadlet from size, coding and packet size
// - frame byte count includes payload, padding and feature data
// - column step in upper half of position register: 1 mono, 2 colour
// - row step in lower half of position register: 1 mono, 2 colour
// - frame period register refreshes when a period setting changes
// - frame period is a single-precision float filling the quadlet
// - bit 0 of every register is its most significant bit
// - only the latest size write is checked, once its count is done; a bad size flags and blocks capture
module ppi_packet_regs
  import ppi_pkg::*;
#(
  parameter bit          COLOR_MODEL = 1'b0,
  parameter logic [31:0] MAX_PPF     = PPI_MAX_PPF
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic [63:0] i_frame_bytes,
  input  wire logic [15:0] i_iso_slots,
  input  wire logic [15:0] i_max_pkt_size,
  input  wire logic        i_settings_changed,
  input  wire logic [31:0] i_frame_period_fp,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_ack,
  output logic      [15:0] o_pkt_size,
  output logic      [31:0] o_frame_packets,
  output logic             o_pkt_size_err,
  output logic             o_capture_allow
);
  // ==========================================================
  // state
  typedef struct packed
  {
    ppi_state_t  st;
    logic [15:0] pkt;
    logic [15:0] rec;
    logic [31:0] ppf;
    logic [31:0] period;
    logic        err;
    logic        chk;
    logic        pend;
    logic        go;
    logic [63:0] dvd;
    logic [15:0] dvs;
    logic [31:0] rdata;
    logic        ack;
  } ppi_regs_state_t;

  localparam ppi_regs_state_t RESET_STATE =
    '{st: PPI_IDLE, pkt: PPI_PKT_RST, pend: 1'b1, default: '0};
  localparam logic [15:0] POS_STEP = COLOR_MODEL ? PPI_STEP_COLOR : PPI_STEP_MONO;

  ppi_regs_state_t regs_reg;
  ppi_regs_state_t regs_next;
  ppi_div_if       div_bus ();

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  // round up to the packet unit, never above the largest size
  function automatic logic [15:0] rec_size(input logic [31:0] q, input logic [15:0] mx);
    logic [31:0] t;
    t = q + {16'h0000, PPI_PKT_UNIT - 16'h0001};
    if (q >= {16'h0000, mx})
      rec_size = mx;
    else if ({t[31:2], 2'b00} > {16'h0000, mx})
      rec_size = mx;
    else
      rec_size = {t[15:2], 2'b00};
  endfunction : rec_size

  function automatic logic bad_size(input logic [15:0] p, input logic [31:0] n,
                                    input logic [15:0] mx);
    bad_size = (p == 16'h0000) || (p[1:0] != 2'b00) || (p > mx) || (n > MAX_PPF);
  endfunction : bad_size

  // ==========================================================
  // sequencer: packets per frame first, then recommended size
  always_comb
  begin
    regs_next = regs_reg;
    regs_next.go = 1'b0;
    regs_next.ack = 1'b0;
    case (regs_reg.st)
      PPI_IDLE:
      begin
        if (regs_reg.pend)
        begin
          regs_next.pend = 1'b0;
          regs_next.go = 1'b1;
          regs_next.dvd = i_frame_bytes;
          regs_next.dvs = regs_reg.pkt;
          regs_next.st = PPI_PPF;
        end
      end
      PPI_PPF:
      begin
        if (div_bus.done)
        begin
          regs_next.ppf = div_bus.quotient;
          regs_next.go = 1'b1;
          regs_next.dvs = (i_iso_slots == 16'h0000) ? 16'h0001 : i_iso_slots;
          regs_next.st = PPI_REC;
        end
      end
      PPI_REC:
      begin
        if (div_bus.done)
        begin
          regs_next.rec = rec_size(div_bus.quotient, i_max_pkt_size);
          // a size written mid-run is judged by the rerun, whose count matches it
          if (regs_reg.chk && !regs_reg.pend)
          begin
            regs_next.chk = 1'b0;
            regs_next.err = bad_size(regs_reg.pkt, regs_reg.ppf, i_max_pkt_size);
          end
          regs_next.st = PPI_IDLE;
        end
      end
      default:
        regs_next.st = PPI_IDLE;
    endcase
    // later assignments win, so a new request is never lost to a clear
    if (i_settings_changed)
    begin
      regs_next.pend = 1'b1;
      regs_next.period = i_frame_period_fp;
    end
    if (i_reg_wr || i_reg_rd)
      regs_next.ack = 1'b1;
    if (i_reg_wr && hit(i_reg_addr, PPI_OFF_PKT_SIZE))
    begin
      // lower half and the other offsets are inquiry only
      regs_next.pkt = i_reg_wdata[PPI_HI_MSB:PPI_HI_LSB];
      regs_next.pend = 1'b1;
      regs_next.chk = 1'b1;
    end
    if (i_reg_rd)
    begin
      if (hit(i_reg_addr, PPI_OFF_PKT_SIZE))
        regs_next.rdata = {regs_reg.pkt, regs_reg.rec};
      else if (hit(i_reg_addr, PPI_OFF_PPF))
        regs_next.rdata = regs_reg.ppf;
      else if (hit(i_reg_addr, PPI_OFF_POS_STEP))
        regs_next.rdata = {POS_STEP, POS_STEP};
      else if (hit(i_reg_addr, PPI_OFF_PERIOD))
        regs_next.rdata = regs_reg.period;
      else
        regs_next.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      regs_reg <= RESET_STATE;
    else
      regs_reg <= regs_next;
  end

  assign div_bus.start = regs_reg.go;
  assign div_bus.dividend = regs_reg.dvd;
  assign div_bus.divisor = regs_reg.dvs;

  // one shared divider: slower, but two wide dividers cost far more area
  ppi_ceil_div u_div
  (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .bus       (div_bus)
  );

  assign o_reg_rdata = regs_reg.rdata;
  assign o_reg_ack = regs_reg.ack;
  assign o_pkt_size = regs_reg.pkt;
  assign o_frame_packets = regs_reg.ppf;
  assign o_pkt_size_err = regs_reg.err;
  assign o_capture_allow = !regs_reg.err;

  // ==========================================================
  // checks
  logic [63:0] chk_hi;
  logic [63:0] chk_lo;
  assign chk_hi = {32'h0000_0000, div_bus.quotient} * {48'h0000_0000_0000, regs_reg.dvs};
  assign chk_lo = chk_hi - {48'h0000_0000_0000, regs_reg.dvs};

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_size_write_take: assert property (
    (i_reg_wr && hit(i_reg_addr, PPI_OFF_PKT_SIZE))
      |=> o_pkt_size == $past(i_reg_wdata[PPI_HI_MSB:PPI_HI_LSB]))
    else $error("packet size not taken from upper half");
  a_read_msb_first: assert property (
    (i_reg_rd && hit(i_reg_addr, PPI_OFF_PKT_SIZE))
      |=> o_reg_ack && o_reg_rdata[PPI_HI_MSB:PPI_HI_LSB] == $past(regs_reg.pkt))
    else $error("size field not in bits 0 to 15");
  a_rec_aligned: assert property (
    (regs_reg.st == PPI_REC && div_bus.done && i_max_pkt_size[1:0] == 2'b00)
      |=> regs_reg.rec[1:0] == 2'b00 && regs_reg.rec <= $past(i_max_pkt_size))
    else $error("recommended size not aligned or too big");
  a_recalc_start: assert property (
    (i_settings_changed && regs_reg.st == PPI_IDLE) |=> ##1 regs_reg.st == PPI_PPF)
    else $error("setting change did not start recompute");
  a_ppf_ceiling: assert property (
    (regs_reg.st == PPI_PPF && div_bus.done && div_bus.quotient != 32'hFFFF_FFFF)
      |-> chk_hi >= regs_reg.dvd && (div_bus.quotient == 32'h0000_0000 || chk_lo < regs_reg.dvd))
    else $error("packets per frame not rounded up");
  a_ppf_latch: assert property (
    (regs_reg.st == PPI_PPF && div_bus.done) |=> o_frame_packets == $past(div_bus.quotient))
    else $error("packets per frame not stored");
  a_step_value: assert property (
    (i_reg_rd && hit(i_reg_addr, PPI_OFF_POS_STEP)) |=> o_reg_rdata == {POS_STEP, POS_STEP})
    else $error("position steps wrong");
  a_period_update: assert property (
    i_settings_changed |=> regs_reg.period == $past(i_frame_period_fp))
    else $error("frame period not refreshed");
  a_inquiry_ro: assert property (
    (i_reg_wr && !hit(i_reg_addr, PPI_OFF_PKT_SIZE) && !i_settings_changed)
      |=> $stable(regs_reg.period) && $stable(regs_reg.pkt))
    else $error("inquiry write changed state");
  a_bad_size_flag: assert property (
    (i_reg_wr && hit(i_reg_addr, PPI_OFF_PKT_SIZE) && i_reg_wdata[PPI_HI_MSB:PPI_HI_LSB] == 16'h0000
      && regs_reg.st == PPI_IDLE && !regs_reg.pend && !i_settings_changed)
      |-> ##[1:200] (o_pkt_size_err || i_reg_wr || i_settings_changed))
    else $error("zero packet size not flagged");

  c_size_write: cover property (i_reg_wr && hit(i_reg_addr, PPI_OFF_PKT_SIZE));
  c_err_raised: cover property ($rose(o_pkt_size_err));
  c_rec_done:   cover property (regs_reg.st == PPI_REC && div_bus.done);
  c_rerun:      cover property (regs_reg.st == PPI_REC && div_bus.done && regs_reg.pend);
endmodule : ppi_packet_regs

// file: rtl/ppi_pkg.sv
package ppi_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] PPI_OFF_PKT_SIZE = 12'h044;
  localparam logic [11:0] PPI_OFF_PPF      = 12'h048;
  localparam logic [11:0] PPI_OFF_POS_STEP = 12'h04C;
  localparam logic [11:0] PPI_OFF_PERIOD   = 12'h050;
  // ==========================================================
  // field positions, bit 0 of the register is the msb
  localparam int PPI_HI_MSB = 31;
  localparam int PPI_HI_LSB = 16;
  localparam int PPI_LO_MSB = 15;
  localparam int PPI_LO_LSB = 0;
  // ==========================================================
  // reset values and limits
  localparam logic [15:0] PPI_PKT_RST     = 16'h0400;
  localparam logic [31:0] PPI_MAX_PPF     = 32'h0000_0FFF;
  localparam logic [15:0] PPI_PKT_UNIT    = 16'h0004;
  localparam logic [15:0] PPI_STEP_MONO   = 16'h0001;
  localparam logic [15:0] PPI_STEP_COLOR  = 16'h0002;
  localparam logic [6:0]  PPI_DIV_LAST    = 7'h3F;
  localparam int          PPI_DIV_LATENCY = 65;
  // ==========================================================
  // recompute sequencer
  typedef enum logic [2:0]
  {
    PPI_IDLE = 3'b001,
    PPI_PPF  = 3'b010,
    PPI_REC  = 3'b100
  } ppi_state_t;
endpackage : ppi_pkg

// file: rtl/ppi_div_if.sv
`timescale 1ns/1ns
interface ppi_div_if;
  logic        start;
  logic [63:0] dividend;
  logic [15:0] divisor;
  logic        done;
  logic [31:0] quotient;
  modport ctrl (output start, output dividend, output divisor, input done, input quotient);
  modport div  (input start, input dividend, input divisor, output done, output quotient);
endinterface : ppi_div_if

// file: rtl/ppi_ceil_div.sv
`timescale 1ns/1ns
module ppi_ceil_div
  import ppi_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  ppi_div_if.div    bus
);
  // ==========================================================
  // state
  typedef struct packed
  {
    logic        busy;
    logic [6:0]  cnt;
    logic [16:0] rem;
    logic [63:0] quo;
    logic [15:0] dvs;
    logic        done;
    logic [31:0] res;
  } ppi_div_state_t;

  ppi_div_state_t div_reg;
  ppi_div_state_t div_next;

  // ceiling of quotient, saturated to one quadlet
  function automatic logic [31:0] ceil_sat(input logic [63:0] q, input logic [16:0] r);
    logic up;
    up = (r != 17'h0_0000);
    if ((q[63:32] != 32'h0000_0000) || (up && (q[31:0] == 32'hFFFF_FFFF)))
      ceil_sat = 32'hFFFF_FFFF;
    else
      ceil_sat = q[31:0] + {31'h0000_0000, up};
  endfunction : ceil_sat

  // ==========================================================
  // restoring divider, one bit a cycle; a zero divisor saturates
  always_comb
  begin
    logic [16:0] sh;
    logic [63:0] q;
    sh = 17'h0_0000;
    q = 64'h0000_0000_0000_0000;
    div_next = div_reg;
    div_next.done = 1'b0;
    if (!div_reg.busy && bus.start)
    begin
      div_next.busy = 1'b1;
      div_next.cnt = 7'h00;
      div_next.rem = 17'h0_0000;
      div_next.quo = bus.dividend;
      div_next.dvs = bus.divisor;
    end
    else if (div_reg.busy)
    begin
      sh = {div_reg.rem[15:0], div_reg.quo[63]};
      q = {div_reg.quo[62:0], 1'b0};
      if (sh >= {1'b0, div_reg.dvs})
      begin
        sh = sh - {1'b0, div_reg.dvs};
        q[0] = 1'b1;
      end
      div_next.rem = sh;
      div_next.quo = q;
      div_next.cnt = div_reg.cnt + 7'h01;
      if (div_reg.cnt == PPI_DIV_LAST)
      begin
        div_next.busy = 1'b0;
        div_next.done = 1'b1;
        div_next.res = ceil_sat(q, sh);
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  assign bus.done = div_reg.done;
  assign bus.quotient = div_reg.res;

  // ==========================================================
  // checks
  a_div_latency: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (bus.start && !div_reg.busy) |-> ##PPI_DIV_LATENCY bus.done)
    else $error("divider result late or early");
endmodule : ppi_ceil_div

// file: verif/ppi_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// host side of the quadlet register bus
module ppi_host_model
(
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_reg_rdata,
  input  wire logic        i_reg_ack,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [11:0] o_reg_addr,
  output logic      [31:0] o_reg_wdata
);
  initial
  begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 12'h000;
    o_reg_wdata = 32'h0000_0000;
  end
  // one access: strobe pulses for one cycle, ack is taken the cycle after
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(negedge i_sys_clk);
    o_reg_wr    = wr;
    o_reg_rd    = ~wr;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    // released lines must not keep their last value
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
    q           = i_reg_rdata;
    ok          = i_reg_ack;
  endtask : xfer
endmodule : ppi_host_model

// file: verif/format7_packet_inquiry_regs_bench.sv
`timescale 1ns/1ns
module format7_packet_inquiry_regs_bench;
  import ppi_pkg::*;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, chg, reg_ack, size_err, cap_allow;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, frame_packets, period_fp;
  logic [63:0] frame_bytes;
  logic [15:0] iso_slots, max_pkt, pkt_size;
  logic [31:0] rdata_color;
  int          fails;
  int          n_compared;
  // ==========================================================
  // size table: good, too many packets, odd step, zero, over max, good
  logic [15:0] sz [6] = '{16'h0014, 16'h0010, 16'h0016, 16'h0000, 16'h1004, 16'h0014};
  logic [31:0] pp [6] = '{32'h0000_0CCD, 32'h0000_1000, 32'h0000_0BA3,
                          32'hFFFF_FFFF, 32'h0000_0010, 32'h0000_0CCD};
  logic        er [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  ppi_packet_regs #(.COLOR_MODEL(1'b0)) u_ppi_packet_regs (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_frame_bytes(frame_bytes),
    .i_iso_slots(iso_slots), .i_max_pkt_size(max_pkt), .i_settings_changed(chg),
    .i_frame_period_fp(period_fp), .o_reg_rdata(reg_rdata), .o_reg_ack(reg_ack),
    .o_pkt_size(pkt_size), .o_frame_packets(frame_packets),
    .o_pkt_size_err(size_err), .o_capture_allow(cap_allow));

  // colour model on the same bus: only its read data is watched
  ppi_packet_regs #(.COLOR_MODEL(1'b1)) u_ppi_packet_regs_color (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_frame_bytes(frame_bytes),
    .i_iso_slots(iso_slots), .i_max_pkt_size(max_pkt), .i_settings_changed(chg),
    .i_frame_period_fp(period_fp), .o_reg_rdata(rdata_color), .o_reg_ack(),
    .o_pkt_size(), .o_frame_packets(), .o_pkt_size_err(), .o_capture_allow());

  ppi_host_model u_ppi_host_model (
    .i_sys_clk(sys_clk), .i_reg_rdata(reg_rdata), .i_reg_ack(reg_ack),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    u_ppi_host_model.xfer(1'b0, a, 32'h0000_0000, q, ok);
    chk({31'h0, ok}, 32'h0000_0001);
    chk(q, exp);
  endtask : rdc

  task automatic wrq(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    u_ppi_host_model.xfer(1'b1, a, d, q, ok);
    chk({31'h0, ok}, 32'h0000_0001);
  endtask : wrq

  // recompute finishes 133 cycles after its request is taken
  task automatic settle();
    repeat (140) @(negedge sys_clk);
  endtask : settle

  task automatic pulse_chg();
    @(negedge sys_clk);
    chg = 1'b1;
    @(negedge sys_clk);
    chg = 1'b0;
  endtask : pulse_chg

  // ==========================================================
  // scenarios
  task automatic t_reset();
    @(negedge sys_clk);
    chk({16'h0, pkt_size}, 32'h0000_0400);
    chk({30'h0, cap_allow, size_err}, 32'h0000_0002);
    settle();
    rdc(PPI_OFF_PKT_SIZE, 32'h0400_0100);
    rdc(PPI_OFF_PPF, 32'h0000_0004);
    rdc(PPI_OFF_PERIOD, 32'h0000_0000);
  endtask : t_reset

  task automatic t_sizes();
    @(negedge sys_clk);
    frame_bytes = 64'h0000_0000_0001_0000;
    foreach (sz[i])
    begin
      wrq(PPI_OFF_PKT_SIZE, {sz[i], 16'hFFFF});
      settle();
      chk(frame_packets, pp[i]);
      rdc(PPI_OFF_PPF, pp[i]);
      rdc(PPI_OFF_PKT_SIZE, {sz[i], 16'h1000});
      chk({30'h0, cap_allow, size_err}, {30'h0, ~er[i], er[i]});
    end
    // a size written while the count for the previous one is still running
    wrq(PPI_OFF_PKT_SIZE, 32'h0010_0000);
    repeat (20) @(negedge sys_clk);
    wrq(PPI_OFF_PKT_SIZE, 32'h0014_0000);
    settle();
    settle();
    chk(frame_packets, 32'h0000_0CCD);
    chk({30'h0, cap_allow, size_err}, 32'h0000_0002);
  endtask : t_sizes

  task automatic t_settings();
    @(negedge sys_clk);
    frame_bytes = 64'h0000_0000_0000_2000;
    iso_slots   = 16'h0064;
    period_fp   = 32'h3D08_8889;
    pulse_chg();
    settle();
    rdc(PPI_OFF_PKT_SIZE, 32'h0014_0054);
    rdc(PPI_OFF_PPF, 32'h0000_019A);
    rdc(PPI_OFF_PERIOD, 32'h3D08_8889);
    iso_slots = 16'h0001;
    pulse_chg();
    settle();
    rdc(PPI_OFF_PKT_SIZE, 32'h0014_1000);
  endtask : t_settings

  task automatic t_readonly();
    wrq(PPI_OFF_PERIOD, 32'h0000_0000);
    rdc(PPI_OFF_PERIOD, 32'h3D08_8889);
    wrq(PPI_OFF_PPF, 32'h1234_5678);
    rdc(PPI_OFF_PPF, 32'h0000_019A);
    rdc(PPI_OFF_POS_STEP, 32'h0001_0001);
    chk(rdata_color, 32'h0002_0002);
    wrq(PPI_OFF_POS_STEP, 32'hFFFF_FFFF);
    rdc(PPI_OFF_POS_STEP, 32'h0001_0001);
    rdc(12'h060, 32'h0000_0000);
  endtask : t_readonly

  // reset after a finished run must clear a raised flag and restart the counts
  task automatic t_rearm();
    wrq(PPI_OFF_PKT_SIZE, 32'h0000_0000);
    settle();
    chk({30'h0, cap_allow, size_err}, 32'h0000_0001);
    frame_bytes = 64'h0000_0000_0000_1000;
    iso_slots   = 16'h0010;
    sys_rst     = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
  endtask : t_rearm

  // ==========================================================
  // run control
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // the tests need under two thousand cycles; this leaves a wide margin
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out();
  end

  initial
  begin
    fails       = 0;
    n_compared  = 0;
    sys_rst     = 1'b1;
    chg         = 1'b0;
    frame_bytes = 64'h0000_0000_0000_1000;
    iso_slots   = 16'h0010;
    max_pkt     = 16'h1000;
    period_fp   = 32'h0000_0000;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_sizes();
    t_settings();
    t_readonly();
    t_rearm();
    close_out();
  end
endmodule : format7_packet_inquiry_regs_bench
